// ==== tap_threshold_timing_bench.sv ====
`timescale 1ns/1ps
module tap_threshold_timing_bench;
	import tapt_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce, wr, rd, tick, lpf, lnm, abt, pv, ign, dab;
	logic [7:0] addr, wdata, rdata, ax, ay, az, v;
	logic [2:0] rate, over, axes;
	logic [1:0] mode;
	int fail_count = 0;
	int n_compared = 0;
	int n_pulse = 0;
	int n_abort = 0;
	int cyc = 0;
	// ce, address, write data, expected read
	logic [31:0] rows [7] = '{32'h0123_9515, 32'h0124_ff7f, 32'h0125_8000,
		32'h0126_ffff, 32'h0127_a5a5, 32'h0128_5a00, 32'h0026_11ff};
	always #4 clk = ~clk;
	tapt_core u_tapt_core (.core_clk_in(clk), .nrst_in(nrst), .ce_in(ce),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .sample_tick_in(tick),
		.accel_x_in(ax), .accel_y_in(ay), .accel_z_in(az),
		.output_sample_rate_in(rate), .oversample_mode_in(mode),
		.tap_lowpass_enable_in(lpf), .low_power_low_noise_mode_in(lnm),
		.double_tap_abort_in(abt), .axis_over_out(over),
		.pulse_valid_out(pv), .pulse_axes_out(axes),
		.ignore_active_out(ign), .dtap_abort_out(dab));
	tapt_host u_tapt_host (.core_clk_in(clk), .reg_rdata_in(rdata),
		.ce_out(ce), .reg_addr_out(addr), .reg_wdata_out(wdata),
		.reg_wr_out(wr), .reg_rd_out(rd));
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tk(input logic [7:0] x, y, z, input int n);
		repeat (n) begin
			@(negedge clk);
			{ax, ay, az} = {x, y, z};
			tick = 1'b1;
			@(negedge clk);
			tick = 1'b0;
		end
	endtask
	// hang guard, whole run needs about 216 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pv === 1'b1)
			n_pulse <= n_pulse + 1;
		if (dab === 1'b1)
			n_abort <= n_abort + 1;
		if (cyc == 2000) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		{tick, lpf, lnm, abt, rate, mode, ax, ay, az} = '0;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		for (int i = 0; i < 5; i++) begin
			u_tapt_host.rd(8'h23 + i[7:0], v);
			check(v, 8'h00);
		end
		for (int i = 0; i < 7; i++) begin
			u_tapt_host.wr(rows[i][23:16], rows[i][15:8], rows[i][24]);
			u_tapt_host.rd(rows[i][23:16], v);
			check(v, rows[i][7:0]);
		end
		$display("registers done");
		u_tapt_host.wr(TAPT_OFF_THR_X, 8'h05);
		u_tapt_host.wr(TAPT_OFF_THR_Y, 8'h20);
		u_tapt_host.wr(TAPT_OFF_THR_Z, 8'h00);
		u_tapt_host.wr(TAPT_OFF_DUR, 8'h02);
		u_tapt_host.wr(TAPT_OFF_IGN, 8'h01);
		tk(8'h09, 8'h09, 8'h00, 2);
		check({5'h00, over}, 8'h01);
		tk(8'h00, 8'h00, 8'h00, 5);
		check({5'h00, axes}, 8'h01);
		check(n_pulse[7:0], 8'h01);
		tk(8'h09, 8'h00, 8'h00, 3);
		tk(8'h00, 8'h00, 8'h00, 5);
		check(n_pulse[7:0], 8'h01);
		$display("short and long pulse done");
		// step of four ticks lets a six-tick pulse pass
		rate = 3'h1;
		lpf = 1'b1;
		tk(8'h09, 8'h00, 8'h00, 6);
		tk(8'h00, 8'h00, 8'h00, 20);
		check(n_pulse[7:0], 8'h02);
		rate = 3'h0;
		lpf = 1'b0;
		lnm = 1'b1;
		u_tapt_host.wr(TAPT_OFF_THR_Z, 8'h7f);
		tk(8'h00, 8'h00, 8'h50, 2);
		check({5'h00, over}, 8'h04);
		tk(8'h00, 8'h00, 8'h00, 5);
		check(n_pulse[7:0], 8'h03);
		check({5'h00, axes}, 8'h04);
		lnm = 1'b0;
		$display("step and cap done");
		u_tapt_host.wr(TAPT_OFF_IGN, 8'h08);
		abt = 1'b1;
		tk(8'h09, 8'h00, 8'h00, 1);
		tk(8'h00, 8'h00, 8'h00, 1);
		tk(8'h09, 8'h00, 8'h00, 1);
		tk(8'h00, 8'h00, 8'h00, 1);
		check({7'h00, ign}, 8'h01);
		tk(8'h00, 8'h00, 8'h00, 12);
		check({7'h00, ign}, 8'h01);
		tk(8'h00, 8'h00, 8'h00, 4);
		check({7'h00, ign}, 8'h00);
		check(n_pulse[7:0], 8'h04);
		check(n_abort[7:0], 8'h01);
		$display("ignore interval done");
		print_verdict();
	end
endmodule

// ==== tapt_core.sv ====
`timescale 1ns/1ps
// How it works
// - each axis compares against its own separate threshold only.
// - threshold fields are seven unsigned bits; register bit 7 reads zero.
// - codes 1 to 127 at fixed 0.063 g per step; zero disables axis.
// - with low-noise set, effective threshold is capped at 4g.
// - detection starts when an axis rises above its threshold.
// - pulse valid only if it falls back within the duration limit.
// - duration limit is its 8-bit value times the step, max 255.
// - step chosen by sample rate, oversampling mode and tap low-pass enable.
// - low-pass on: 1.25 ms fastest, doubling per rate halving, per mode.
// - low-pass off: 0.625 ms fastest, growing per mode up to 40 ms.
// - after a valid pulse, further pulses ignored until interval ends.
// - ignore interval is its 8-bit value times its step, max 255.
// - thresholds, duration limit and ignore interval reset to zero.
// - ignore interval step is twice the duration step.
// - with abort set, a pulse inside the interval aborts double tap.
module tapt_core
	import tapt_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic sample_tick_in,
	input wire logic [7:0] accel_x_in,
	input wire logic [7:0] accel_y_in,
	input wire logic [7:0] accel_z_in,
	input wire logic [2:0] output_sample_rate_in,
	input wire logic [1:0] oversample_mode_in,
	input wire logic tap_lowpass_enable_in,
	input wire logic low_power_low_noise_mode_in,
	input wire logic double_tap_abort_in,
	output logic [2:0] axis_over_out,
	output logic pulse_valid_out,
	output logic [2:0] pulse_axes_out,
	output logic ignore_active_out,
	output logic dtap_abort_out
);
	import tapt_pkg::*;

	tapt_st_t q;
	tapt_st_t n;
	logic [6:0] thr_eff [3];
	logic [2:0] above;
	logic [3:0] sh_dur;
	logic [3:0] sh;
	logic [9:0] ratio_m1;
	logic step;
	logic fell;

	always_comb begin
		logic [6:0] thr_raw [3];
		logic [7:0] mag [3];
		logic [31:0] tbl;
		tbl = 32'h0000_0000;
		thr_raw[0] = q.thr_x;
		thr_raw[1] = q.thr_y;
		thr_raw[2] = q.thr_z;
		mag[0] = accel_x_in;
		mag[1] = accel_y_in;
		mag[2] = accel_z_in;
		for (int i = 0; i < 3; i++) begin
			if (low_power_low_noise_mode_in &&
				thr_raw[i] > TAPT_LOW_NOISE_CAP) begin
				thr_eff[i] = TAPT_LOW_NOISE_CAP;
			end else begin
				thr_eff[i] = thr_raw[i];
			end
			above[i] = (thr_eff[i] != 7'h00) && (mag[i] > {1'b0, thr_eff[i]});
		end
		if (tap_lowpass_enable_in) begin
			tbl = TAPT_SHIFT_LPF_ON[oversample_mode_in];
		end else begin
			tbl = TAPT_SHIFT_LPF_OFF[oversample_mode_in];
		end
		sh_dur = tbl[{output_sample_rate_in, 2'b00} +: 4];
		sh = (q.state == TAPT_IGNORE) ? sh_dur + 4'h1 : sh_dur;
		ratio_m1 = 10'((11'h001 << sh) - 11'h001);
	end

	assign step = sample_tick_in && (q.pre == ratio_m1);
	assign fell = !(|(above & q.axes));

	always_comb begin
		n = q;
		n.valid = 1'b0;
		n.abort = 1'b0;
		if (reg_wr_in) begin
			if (reg_addr_in == TAPT_OFF_THR_X) begin
				n.thr_x = reg_wdata_in[6:0];
			end else if (reg_addr_in == TAPT_OFF_THR_Y) begin
				n.thr_y = reg_wdata_in[6:0];
			end else if (reg_addr_in == TAPT_OFF_THR_Z) begin
				n.thr_z = reg_wdata_in[6:0];
			end else if (reg_addr_in == TAPT_OFF_DUR) begin
				n.dur_limit = reg_wdata_in;
			end else if (reg_addr_in == TAPT_OFF_IGN) begin
				n.ign_interval = reg_wdata_in;
			end
		end
		if (reg_rd_in) begin
			// bit 7 of thresholds reads zero
			if (reg_addr_in == TAPT_OFF_THR_X) begin
				n.rdata = {1'b0, q.thr_x};
			end else if (reg_addr_in == TAPT_OFF_THR_Y) begin
				n.rdata = {1'b0, q.thr_y};
			end else if (reg_addr_in == TAPT_OFF_THR_Z) begin
				n.rdata = {1'b0, q.thr_z};
			end else if (reg_addr_in == TAPT_OFF_DUR) begin
				n.rdata = q.dur_limit;
			end else if (reg_addr_in == TAPT_OFF_IGN) begin
				n.rdata = q.ign_interval;
			end else begin
				n.rdata = 8'h00;
			end
		end
		if (sample_tick_in) begin
			n.over = above;
			n.pre = step ? 10'h000 : q.pre + 10'h001;
		end
		case (q.state)
			TAPT_IDLE: begin
				if (sample_tick_in && (|above)) begin
					n.state = TAPT_TIMING;
					n.axes = above;
					n.cnt = 8'h00;
					n.pre = 10'h000;
				end
			end
			TAPT_TIMING: begin
				if (sample_tick_in) begin
					if (fell && q.cnt < q.dur_limit) begin
						n.valid = 1'b1;
						n.cnt = 8'h00;
						n.pre = 10'h000;
						n.lat_seen = 1'b0;
						n.state = (q.ign_interval == 8'h00) ? TAPT_IDLE : TAPT_IGNORE;
					end else if (q.cnt == q.dur_limit) begin
						n.state = TAPT_WAIT_FALL;
					end else if (step) begin
						n.cnt = q.cnt + 8'h01;
					end
				end
			end
			TAPT_WAIT_FALL: begin
				if (sample_tick_in && !(|above)) begin
					n.state = TAPT_IDLE;
				end
			end
			TAPT_IGNORE: begin
				if (sample_tick_in) begin
					if (|above) begin
						n.lat_seen = 1'b1;
					end else if (q.lat_seen) begin
						n.lat_seen = 1'b0;
						n.abort = double_tap_abort_in;
					end
					if (q.cnt == q.ign_interval) begin
						// a tap still high at the end must not retrigger
						n.state = (|above) ? TAPT_WAIT_FALL : TAPT_IDLE;
					end else if (step) begin
						n.cnt = q.cnt + 8'h01;
					end
				end
			end
			default: begin
				n.state = TAPT_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			q <= '{thr_x: TAPT_THR_RESET, thr_y: TAPT_THR_RESET,
				thr_z: TAPT_THR_RESET, dur_limit: TAPT_DUR_RESET,
				ign_interval: TAPT_IGN_RESET, state: TAPT_IDLE,
				default: '0};
		end else if (ce_in) begin
			q <= n;
		end
	end

	assign reg_rdata_out = q.rdata;
	assign axis_over_out = q.over;
	assign pulse_valid_out = q.valid;
	assign pulse_axes_out = q.axes;
	assign ignore_active_out = (q.state == TAPT_IGNORE);
	assign dtap_abort_out = q.abort;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_start;
		q.state == TAPT_IDLE && ce_in && sample_tick_in && (|above);
	endsequence
	sequence s_valid_pulse;
		ce_in && q.state == TAPT_TIMING && sample_tick_in && fell &&
			q.cnt < q.dur_limit;
	endsequence

	a_start_on_rise: assert property (s_start |=> q.state == TAPT_TIMING)
		else $error("rise over threshold did not start timing");
	a_valid_in_limit: assert property ($rose(q.valid) |->
		$past(q.cnt) < $past(q.dur_limit))
		else $error("pulse flagged valid after its limit");
	a_ignore_follows: assert property (
		(s_valid_pulse and (q.ign_interval != 8'h00))
		|=> q.valid && q.state == TAPT_IGNORE)
		else $error("valid pulse did not open ignore interval");
	a_dur_bound: assert property (q.state == TAPT_TIMING |->
		q.cnt <= q.dur_limit)
		else $error("duration count passed its limit");
	a_ign_bound: assert property (q.state == TAPT_IGNORE |->
		q.cnt <= q.ign_interval)
		else $error("ignore count passed its interval");
	a_low_noise_cap: assert property (low_power_low_noise_mode_in |->
		thr_eff[0] <= TAPT_LOW_NOISE_CAP &&
		thr_eff[1] <= TAPT_LOW_NOISE_CAP &&
		thr_eff[2] <= TAPT_LOW_NOISE_CAP)
		else $error("threshold above 4g in low-noise");
	a_thr_top_zero: assert property (ce_in && reg_rd_in &&
		reg_addr_in == TAPT_OFF_THR_Y |=> reg_rdata_out[7] == 1'b0)
		else $error("threshold bit 7 read as one");
	a_reset_zero: assert property ($rose(nrst_in) |->
		q.thr_x == 7'h00 && q.thr_y == 7'h00 && q.thr_z == 7'h00 &&
		q.dur_limit == 8'h00 && q.ign_interval == 8'h00)
		else $error("registers not zero after reset");
	a_fast_step_on: assert property (output_sample_rate_in == 3'h0 &&
		tap_lowpass_enable_in |-> sh_dur == 4'h1)
		else $error("fastest low-pass step not 1.25 ms");
	a_fast_step_off: assert property (output_sample_rate_in == 3'h0 &&
		!tap_lowpass_enable_in |-> sh_dur == 4'h0)
		else $error("fastest unfiltered step not 0.625 ms");
	a_ign_step_double: assert property (q.state == TAPT_IGNORE |->
		sh == sh_dur + 4'h1)
		else $error("ignore step not twice the duration step");
	a_step_restart: assert property (s_start |=>
		q.pre == 10'h000 && q.cnt == 8'h00)
		else $error("timer not restarted on detection");
	a_abort_in_ign: assert property ($rose(q.abort) |->
		$past(q.state) == TAPT_IGNORE && $past(double_tap_abort_in))
		else $error("abort outside ignore interval");
endmodule

// ==== tapt_host.sv ====
`timescale 1ns/1ps
module tapt_host (
	input wire logic core_clk_in,
	input wire logic [7:0] reg_rdata_in,
	output logic ce_out,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out
);
	initial begin
		ce_out = 1'b1;
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	task automatic wr(input logic [7:0] a, d, input logic ce = 1'b1);
		@(negedge core_clk_in);
		ce_out = ce;
		reg_addr_out = a;
		reg_wdata_out = d;
		reg_wr_out = 1'b1;
		@(negedge core_clk_in);
		reg_wr_out = 1'b0;
		ce_out = 1'b1;
		// data is stale once the strobe drops
		reg_wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk_in);
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(negedge core_clk_in);
		reg_rd_out = 1'b0;
		@(negedge core_clk_in);
		d = reg_rdata_in;
	endtask
endmodule

// ==== tapt_pkg.sv ====
package tapt_pkg;
	// register offsets on the serial register port
	localparam logic [7:0] TAPT_OFF_THR_X = 8'h23;
	localparam logic [7:0] TAPT_OFF_THR_Y = 8'h24;
	localparam logic [7:0] TAPT_OFF_THR_Z = 8'h25;
	localparam logic [7:0] TAPT_OFF_DUR = 8'h26;
	localparam logic [7:0] TAPT_OFF_IGN = 8'h27;
	// field layout and reset values
	localparam int TAPT_THR_W = 7;
	localparam int TAPT_TIMER_W = 8;
	localparam logic [6:0] TAPT_THR_RESET = 7'h00;
	localparam logic [7:0] TAPT_DUR_RESET = 8'h00;
	localparam logic [7:0] TAPT_IGN_RESET = 8'h00;
	// 4g at 0.063 g per code, rounded down so the cap never exceeds 4g
	localparam logic [6:0] TAPT_LOW_NOISE_CAP = 7'h3f;
	// period of the base sample tick, the finest step of any timer
	localparam int TAPT_BASE_STEP_NS = 625000;
	// oversampling modes
	localparam logic [1:0] TAPT_MODE_NORMAL = 2'h0;
	localparam logic [1:0] TAPT_MODE_LOW_POWER_LOW_NOISE_MODE = 2'h1;
	localparam logic [1:0] TAPT_MODE_HIRES = 2'h2;
	localparam logic [1:0] TAPT_MODE_LOWPWR = 2'h3;
	// duration step as log2 of base ticks, nibble i for rate code i
	localparam logic [31:0] TAPT_SHIFT_LPF_ON [4] = '{
		32'h5555_4321, 32'h7775_4321, 32'h2222_2221, 32'h8875_4321};
	localparam logic [31:0] TAPT_SHIFT_LPF_OFF [4] = '{
		32'h3333_2100, 32'h5553_2100, 32'h0000_0000, 32'h6664_3210};
	typedef enum logic [3:0] {
		TAPT_IDLE = 4'h1,
		TAPT_TIMING = 4'h2,
		TAPT_WAIT_FALL = 4'h4,
		TAPT_IGNORE = 4'h8
	} tapt_state_t;
	typedef struct packed {
		logic [6:0] thr_x;
		logic [6:0] thr_y;
		logic [6:0] thr_z;
		logic [7:0] dur_limit;
		logic [7:0] ign_interval;
		tapt_state_t state;
		logic [9:0] pre;
		logic [7:0] cnt;
		logic [2:0] axes;
		logic lat_seen;
		logic [7:0] rdata;
		logic [2:0] over;
		logic valid;
		logic abort;
	} tapt_st_t;
endpackage
